/* File: hw/tcr_defines.vh */
// Constants for the temperature conversion and result block
`ifndef TCR_DEFINES_VH
`define TCR_DEFINES_VH

`define TCR_CLK_MHZ 100
`define TCR_CONV_TIME_9BIT_MS 150
`define TCR_CONV_CYC_9BIT (`TCR_CONV_TIME_9BIT_MS * 1000 * `TCR_CLK_MHZ)

`define TCR_RES_9 2'h0
`define TCR_RES_10 2'h1
`define TCR_RES_11 2'h2
`define TCR_RES_12 2'h3
`define TCR_MASK_9 16'hFF80
`define TCR_MASK_10 16'hFFC0
`define TCR_MASK_11 16'hFFE0
`define TCR_MASK_12 16'hFFF0
`define TCR_LOW_ZERO 4'h0

`define TCR_PTR_TEMP 2'h0
`define TCR_PTR_CFG 2'h1
`define TCR_CFG_RESET 8'h00
`define TCR_CFG_WR_MASK 8'h7F
`define TCR_CFG_STOP_BIT 0
`define TCR_CFG_RES_LO_BIT 5
`define TCR_CFG_RES_HI_BIT 6
`define TCR_DEV_ADDR_HI 4'h9
`define TCR_UNUSED_READ 8'h00
`define TCR_BITS_PER_BYTE 4'h8

`endif

/* File: hw/tcr_sync.v */
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module tcr_sync #(
	parameter WIDTH = 1
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule // tcr_sync

/* File: hw/tcr_top.v */
// Background temperature conversion engine with two-wire register access
`timescale 1ns/1ns
`include "tcr_defines.vh"
module tcr_top #(
	parameter [31:0] CONV_CYC_9BIT = `TCR_CONV_CYC_9BIT
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe,
	input wire [2:0] addr_pins,
	input wire [11:0] sensor_code,
	output reg conv_active
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_RXB = 3'h1;
	localparam [2:0] ST_ACK = 3'h2;
	localparam [2:0] ST_TXB = 3'h3;
	localparam [2:0] ST_MACK = 3'h4;

	wire [4:0] pins_s;
	wire scl_s = pins_s[0];
	wire sda_s = pins_s[1];
	wire [2:0] addr_s = pins_s[4:2];

	tcr_sync #(.WIDTH(5)) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.async_in({addr_pins, sda_in, scl_in}),
		.sync_out(pins_s)
	);

	reg scl_prev_reg;
	reg sda_prev_reg;
	wire scl_rise = scl_s & ~scl_prev_reg;
	wire scl_fall = ~scl_s & scl_prev_reg;
	wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	wire stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	reg [7:0] cfg_reg;
	reg [15:0] temperature_result_reg;
	reg [31:0] conv_cnt_reg;
	reg [1:0] conv_res_reg;
	reg [2:0] state_reg;
	reg [3:0] bitcnt_reg;
	reg [1:0] byte_idx_reg;
	reg [7:0] rx_sh_reg;
	reg [7:0] tx_sh_reg;
	reg [1:0] ptr_reg;
	reg rw_reg;
	reg rd_hi_reg;
	reg [15:0] snap_reg;

	wire low_power_stop = cfg_reg[`TCR_CFG_STOP_BIT];
	wire res_sel_lo = cfg_reg[`TCR_CFG_RES_LO_BIT];
	wire res_sel_hi = cfg_reg[`TCR_CFG_RES_HI_BIT];
	wire [1:0] res_code = {res_sel_hi, res_sel_lo};
	wire [31:0] conv_time_max = CONV_CYC_9BIT << conv_res_reg;

	// Unused low bits are masked per resolution; bits 3..0 are always zero
	reg [15:0] res_mask;
	always @* begin
		case (conv_res_reg)
		`TCR_RES_9: res_mask = `TCR_MASK_9;
		`TCR_RES_10: res_mask = `TCR_MASK_10;
		`TCR_RES_11: res_mask = `TCR_MASK_11;
		`TCR_RES_12: res_mask = `TCR_MASK_12;
		default: res_mask = `TCR_MASK_9;
		endcase
	end
	// Sensor code is 12-bit two's complement in 1/16 degree steps
	wire [15:0] new_result = {sensor_code, `TCR_LOW_ZERO} & res_mask;

	// Conversion engine
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			conv_active <= 1'b1;
			conv_cnt_reg <= 32'h00000000;
			conv_res_reg <= `TCR_RES_9;
			temperature_result_reg <= 16'h0000;
		end else if (conv_active) begin
			if (conv_cnt_reg >= conv_time_max - 32'h00000001) begin
				temperature_result_reg <= new_result;
				conv_cnt_reg <= 32'h00000000;
				conv_res_reg <= res_code;
				conv_active <= ~low_power_stop;
			end else begin
				conv_cnt_reg <= conv_cnt_reg + 32'h00000001;
			end
		end else if (!low_power_stop) begin
			conv_active <= 1'b1;
			conv_res_reg <= res_code;
		end
	end

	// Byte returned to the host for the current pointer
	reg [7:0] tx_byte;
	always @* begin
		case (ptr_reg)
		`TCR_PTR_TEMP: tx_byte = rd_hi_reg ? snap_reg[15:8] : snap_reg[7:0];
		`TCR_PTR_CFG: tx_byte = cfg_reg;
		default: tx_byte = `TCR_UNUSED_READ;
		endcase
	end

	// Two-wire slave; reads only copy the stored result, never touch the engine
	always @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
			cfg_reg <= `TCR_CFG_RESET;
			state_reg <= ST_IDLE;
			bitcnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			rx_sh_reg <= 8'h00;
			tx_sh_reg <= 8'h00;
			ptr_reg <= `TCR_PTR_TEMP;
			rw_reg <= 1'b0;
			rd_hi_reg <= 1'b1;
			snap_reg <= 16'h0000;
		end else begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
			sda_out <= 1'b0;
			if (start_det) begin
				state_reg <= ST_RXB;
				bitcnt_reg <= 4'h0;
				byte_idx_reg <= 2'h0;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				state_reg <= ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				case (state_reg)
				ST_IDLE: begin
					sda_oe <= 1'b0;
				end
				ST_RXB: begin
					if (scl_rise) begin
						rx_sh_reg <= {rx_sh_reg[6:0], sda_s};
						bitcnt_reg <= bitcnt_reg + 4'h1;
					end else if (scl_fall && bitcnt_reg == `TCR_BITS_PER_BYTE) begin
						bitcnt_reg <= 4'h0;
						if (byte_idx_reg != 2'h2)
							byte_idx_reg <= byte_idx_reg + 2'h1;
						if (byte_idx_reg == 2'h0) begin
							if (rx_sh_reg[7:1] == {`TCR_DEV_ADDR_HI, addr_s}) begin
								rw_reg <= rx_sh_reg[0];
								snap_reg <= temperature_result_reg;
								rd_hi_reg <= 1'b1;
								sda_oe <= 1'b1;
								state_reg <= ST_ACK;
							end else begin
								state_reg <= ST_IDLE;
							end
						end else begin
							if (byte_idx_reg == 2'h1)
								ptr_reg <= rx_sh_reg[1:0];
							else if (ptr_reg == `TCR_PTR_CFG)
								cfg_reg <= rx_sh_reg & `TCR_CFG_WR_MASK;
							sda_oe <= 1'b1;
							state_reg <= ST_ACK;
						end
					end
				end
				ST_ACK, ST_MACK: begin
					if (state_reg == ST_MACK && scl_rise && sda_s) begin
						state_reg <= ST_IDLE;
					end else if (scl_fall) begin
						if (rw_reg) begin
							sda_oe <= ~tx_byte[7];
							tx_sh_reg <= {tx_byte[6:0], 1'b0};
							rd_hi_reg <= ~rd_hi_reg;
							bitcnt_reg <= 4'h1;
							state_reg <= ST_TXB;
						end else begin
							sda_oe <= 1'b0;
							state_reg <= ST_RXB;
						end
					end
				end
				ST_TXB: begin
					if (scl_fall) begin
						if (bitcnt_reg == `TCR_BITS_PER_BYTE) begin
							sda_oe <= 1'b0;
							bitcnt_reg <= 4'h0;
							state_reg <= ST_MACK;
						end else begin
							sda_oe <= ~tx_sh_reg[7];
							tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
							bitcnt_reg <= bitcnt_reg + 4'h1;
						end
					end
				end
				default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
endmodule // tcr_top

/* File: test/tcr_host.sv */
// Two-wire bus host that writes the configuration and reads results
`timescale 1ns/1ns
module tcr_host #(
	parameter [2:0] ADDR = 3'h0
) (
	output reg scl,
	output reg pull_low,
	input wire sda
);
	reg [7:0] q;
	reg s;
	reg nak;
	initial begin
		scl = 1'h1;
		pull_low = 1'h0;
		nak = 1'h0;
	end
	// Data moves mid low phase, so the device never sees it change under a high clock
	task bio(input reg b, output reg r);
		begin
			#30 pull_low = !b;
			#35 scl = 1'h1;
			r = sda;
			#60 scl = 1'h0;
		end
	endtask
	task byte_io(input [7:0] d, input reg m, output reg [7:0] r);
		integer k;
		begin
			for (k = 7; k >= 0; k = k - 1)
				bio(d[k], r[k]);
			bio(m, s);
		end
	endtask
	task wb(input [7:0] d);
		begin
			byte_io(d, 1'h1, q);
			nak = nak | s;
		end
	endtask
	// Frames start 1 ns past a 10 ns boundary and all steps are multiples of 5 ns,
	// so no pin ever changes on a rising edge of the 10 ns system clock
	task start;
		begin
			#(11 - ($time % 10));
			#30 pull_low = 1'h0;
			#30 scl = 1'h1;
			#30 pull_low = 1'h1;
			#30 scl = 1'h0;
		end
	endtask
	task stop;
		begin
			#30 pull_low = 1'h1;
			#30 scl = 1'h1;
			#30 pull_low = 1'h0;
		end
	endtask
	task wr_cfg(input [7:0] v);
		begin
			start;
			wb({4'h9, ADDR, 1'h0});
			wb(8'h01);
			wb(v);
			stop;
		end
	endtask
	// Read at the current pointer; the address byte, which latches the result, ends before a first conversion
	task rd_cur(output reg [15:0] t);
		begin
			start;
			wb({4'h9, ADDR, 1'h1});
			byte_io(8'hFF, 1'h0, t[15:8]);
			byte_io(8'hFF, 1'h1, t[7:0]);
			stop;
		end
	endtask
	task rd_ptr(input [7:0] p, output reg [15:0] t);
		begin
			start;
			wb({4'h9, ADDR, 1'h0});
			wb(p);
			rd_cur(t);
		end
	endtask
	task rd_temp(output reg [15:0] t);
		begin
			rd_ptr(8'h00, t);
		end
	endtask
endmodule // tcr_host

/* File: test/tcr_properties.sv */
// Port checker for the conversion block, bound into its top
`timescale 1ns/1ns
module tcr_props #(
	parameter [31:0] CONV_CYC_9BIT = 32'hC8
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire scl_in,
	input wire sda_out,
	input wire sda_oe,
	input wire conv_active
);
	reg [31:0] run_reg;
	always @(posedge clk_sys or posedge sys_rst)
		if (sys_rst)
			run_reg <= 32'h0;
		else
			run_reg <= conv_active ? run_reg + 32'h1 : 32'h0;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_auto; $past(sys_rst) |-> conv_active; endproperty
	// Every conversion length is a power-of-two multiple of the 9-bit length, so a halt
	// on a conversion boundary always leaves a whole multiple of it behind
	property p_full;
		$fell(conv_active) |-> run_reg != 32'h0 && run_reg % CONV_CYC_9BIT == 32'h0;
	endproperty
	property p_span; conv_active && run_reg < CONV_CYC_9BIT - 32'h1 |=> conv_active; endproperty
	property p_resume; $rose(conv_active) |-> conv_active [*8]; endproperty
	property p_drain; sda_out == 1'h0; endproperty
	property p_quiet; $past(sys_rst) |-> !sda_oe; endproperty
	property p_low; $rose(sda_oe) |-> !scl_in; endproperty
	property p_stand; $rose(sda_oe) |-> sda_oe [*6]; endproperty
	property p_high; scl_in [*4] |-> $stable(sda_oe); endproperty
	a_auto: assert property (p_auto) else $error("idle after reset");
	a_full: assert property (p_full) else $error("halt cut conversion");
	a_resume: assert property (p_resume) else $error("short conversion");
	a_span: assert property (p_span) else $error("halt inside first conversion");
	a_drain: assert property (p_drain) else $error("data driven high");
	a_quiet: assert property (p_quiet) else $error("bus busy after reset");
	a_low: assert property (p_low) else $error("data moved under high clock");
	a_stand: assert property (p_stand) else $error("data bit too short");
	a_high: assert property (p_high) else $error("data changed while clock high");
	c_halt: cover property ($fell(conv_active));
	c_run: cover property ($rose(conv_active));
	c_ack: cover property ($rose(sda_oe));
endmodule // tcr_props
bind tcr_top tcr_props #(.CONV_CYC_9BIT(CONV_CYC_9BIT)) u_props (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.conv_active(conv_active));

/* File: test/testbench.sv */
// Self-checking bench for the conversion block
`timescale 1ns/1ns
module testbench;
	reg clk_sys;
	reg sys_rst;
	reg [11:0] sensor_code;
	reg [15:0] t;
	wire scl, pull, sda_out, sda_oe, conv_active;
	wire sda = ~(sda_oe | pull);
	integer miscompares, checks, i, n;
	tcr_top #(.CONV_CYC_9BIT(32'hC8)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_pins(3'h5),
		.sensor_code(sensor_code), .conv_active(conv_active));
	tcr_host #(.ADDR(3'h5)) host (.scl(scl), .pull_low(pull), .sda(sda));
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	task check(input [15:0] seen, input [15:0] want);
		begin
			checks = checks + 1;
			if (seen !== want) begin
				miscompares = miscompares + 1;
				$display("wrong value at %0t: %h not %h", $time, seen, want);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d miscompares %0d", checks, miscompares);
			if (miscompares == 0 && checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wait_act(input reg lvl, input integer lim);
		begin
			n = 0;
			while (conv_active !== lvl && n < lim) begin
				@(posedge clk_sys);
				n = n + 1;
			end
			check(n < lim, 1'h1);
			if (n == lim)
				wrap_up;
		end
	endtask
	initial begin
		miscompares = 0;
		checks = 0;
		sys_rst = 1'h1;
		sensor_code = 12'h191;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
		#1 check(conv_active, 1'h1);
		host.rd_cur(t);
		check(t, 16'h0000);
		host.rd_temp(t);
		check(t, 16'h1900);
		$display("default resolution done");
		// Low code bits all set, so every resolution mask shows in the result
		@(posedge clk_sys) sensor_code <= 12'hE6F;
		// Wait covers the old-resolution conversion plus one at the new one
		for (i = 0; i < 4; i = i + 1) begin
			host.wr_cfg({1'h0, i[1:0], 5'h00});
			repeat (400 << i) @(posedge clk_sys);
			host.rd_temp(t);
			check(t, 16'hE6F0 & (16'hFFF0 << (3 - i)));
		end
		$display("resolution sweep done");
		host.wr_cfg(8'hE1);
		wait_act(1'h0, 1700);
		@(posedge clk_sys) sensor_code <= 12'h0A2;
		repeat (2000) @(posedge clk_sys);
		host.rd_temp(t);
		check(t, 16'hE6F0);
		check(conv_active, 1'h0);
		host.rd_ptr(8'h01, t);
		check(t, 16'h6161);
		host.wr_cfg(8'h00);
		wait_act(1'h1, 20);
		repeat (500) @(posedge clk_sys);
		host.rd_temp(t);
		check(t, 16'h0A00);
		check(host.nak, 1'h0);
		$display("stop and resume done");
		wrap_up;
	end
endmodule // testbench
